// ### include/eldr_pkg.sv
// Constants shared by the identification loader and its word reader
package eldr_pkg;
    localparam int          EE_CLK_DIV      = 256;                // Core clock divide for the link
    localparam int          EE_HALF_CYCLES  = EE_CLK_DIV / 2;     // Cycles per clock half period
    localparam logic [7:0]  EE_HALF_LAST    = 8'(EE_HALF_CYCLES - 1);
    localparam int          EE_WORD_BITS    = 16;                 // Word organisation of the memory
    localparam int          EE_ADDR_BITS    = 6;
    localparam int          EE_CMD_BITS     = 3 + EE_ADDR_BITS;   // Start bit, opcode, address
    localparam logic [2:0]  EE_CMD_READ     = 3'h6;               // Start bit 1, read opcode 10
    localparam logic [4:0]  EE_FIRST_DATA   = 5'(EE_CMD_BITS);    // Falling edge of first data bit
    localparam logic [4:0]  EE_LAST_CLOCK   = 5'(EE_CMD_BITS + EE_WORD_BITS - 1);
    localparam int          ID_WORDS        = 4;                  // Words fetched at start-up
    localparam logic [1:0]  ID_LAST_WORD    = 2'(ID_WORDS - 1);
    localparam logic [1:0]  ID_VENDOR       = 2'h0;               // Word index within the memory
    localparam logic [1:0]  ID_DEVICE       = 2'h1;
    localparam logic [1:0]  ID_SUB_VENDOR   = 2'h2;
    localparam logic [1:0]  ID_SUB_SYSTEM   = 2'h3;
    localparam logic [15:0] ID_SUB_DEFAULT  = 16'h0000;           // Subsystem fields without memory
    localparam logic [2:0]  SENSE_LAST      = 3'h7;               // Settling cycles before sensing
endpackage : eldr_pkg

// ### rtl/eldr_word_reader.sv
// Serial reader for one 16-bit word over the four-wire memory link
`timescale 1ns/10ps
`default_nettype none
module eldr_word_reader (
    input  wire logic        clk_sys,     // Core clock
    input  wire logic        rst_b,       // Synchronous reset, active low
    input  wire logic        start,       // Begin a word read
    input  wire logic [5:0]  word_addr,   // Word address
    input  wire logic        read_bit,    // Synchronised serial read data
    output var  logic        busy,        // Transfer in progress
    output var  logic        done,        // Word complete, one cycle
    output var  logic [15:0] word,        // Received word
    output var  logic        sclk,        // Serial clock
    output var  logic        sel,         // Chip select
    output var  logic        wdata        // Serial write data
);
    logic [7:0]  cnt_q,  cnt_d;
    logic [4:0]  idx_q,  idx_d;
    logic [8:0]  cmd_q,  cmd_d;
    logic [15:0] word_q, word_d;
    logic        sclk_q, sclk_d;
    logic        sel_q,  sel_d;
    logic        di_q,   di_d;
    logic        busy_q, busy_d;
    logic        done_q, done_d;

    always_comb begin
        cnt_d  = cnt_q;
        idx_d  = idx_q;
        cmd_d  = cmd_q;
        word_d = word_q;
        sclk_d = sclk_q;
        sel_d  = sel_q;
        di_d   = di_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (!busy_q) begin
            if (start) begin
                cmd_d  = {eldr_pkg::EE_CMD_READ, word_addr}; // R21
                di_d   = eldr_pkg::EE_CMD_READ[2];
                sel_d  = 1'b1; // R21
                busy_d = 1'b1;
                cnt_d  = 8'h00;
                idx_d  = 5'h00;
                sclk_d = 1'b0;
            end
        end else if (cnt_q == eldr_pkg::EE_HALF_LAST) begin
            cnt_d  = 8'h00;
            sclk_d = ~sclk_q; // R1
            if (sclk_q) begin
                if (idx_q >= eldr_pkg::EE_FIRST_DATA) begin
                    word_d = {word_q[14:0], read_bit}; // R5
                end
                if (idx_q == eldr_pkg::EE_LAST_CLOCK) begin
                    sel_d  = 1'b0; // R21
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    di_d   = 1'b0;
                end else begin
                    idx_d = idx_q + 5'h01;
                    cmd_d = {cmd_q[7:0], 1'b0};
                    di_d  = cmd_q[7];
                end
            end
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_q  <= 8'h00;
            idx_q  <= 5'h00;
            cmd_q  <= 9'h000;
            word_q <= 16'h0000;
            sclk_q <= 1'b0;
            sel_q  <= 1'b0;
            di_q   <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            idx_q  <= idx_d;
            cmd_q  <= cmd_d;
            word_q <= word_d;
            sclk_q <= sclk_d;
            sel_q  <= sel_d;
            di_q   <= di_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy  = busy_q;
    assign done  = done_q;
    assign word  = word_q;
    assign sclk  = sclk_q;
    assign sel   = sel_q;
    assign wdata = di_q;
endmodule : eldr_word_reader // eldr_word_reader
`default_nettype wire

// ### rtl/eldr_loader.sv
// Start-up identification loader, manual link control and strap sampling
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1 - Start-up link clock is the core clock divided by 256.
// R2 - Software toggles the serial clock pin by hand after loading.
// R3 - Software sets the chip-select pin level after loading.
// R4 - Memory presence is sensed from the pulled-up chip-select pin at start-up.
// R5 - Words are 16 bits; software may drive the write-data pin.
// R6 - Software reads the level of the serial read-data pin.
// R7 - The link is four signals: clock, select, write data, read data.
// R8 - Only vendor, device, subsystem vendor and subsystem words are fetched.
// R9 - Without a memory the device runs on built-in identification.
// R10 - Host software may sequence the link by hand for general data.
// R11 - Infrared strap is sampled at start-up, hardware reset and soft reset.
// R12 - Sampled infrared level goes to modem control bit 6, then software-owned.
// R13 - Sampled infrared level starts both channels in infrared mode.
// R14 - High half-duplex strap at reset puts both channels in automatic mode.
// R15 - Automatic half-duplex sets feature control bit 5 in both channels.
// R16 - Software may later set or clear automatic half-duplex freely.
// R17 - Control registers sit in a 1K memory window outside this block.
// R18 - Device and vendor fields hold defaults or loaded words.
// R19 - Subsystem fields hold loaded words, otherwise zero.
// R20 - Identification auto-configuration happens only with a memory fitted.
// R21 - Each word: select, send read command and address, take 16 bits, deselect.
// R22 - Identification is flagged valid only after loading has finished.
module eldr_loader #(
    parameter logic [15:0] DEFAULT_VENDOR_ID = 16'h1234, // Arbitrary value
    parameter logic [15:0] DEFAULT_DEVICE_ID = 16'h5678, // Arbitrary value
    parameter logic [5:0]  ID_BASE_ADDR      = 6'h00     // First word address in memory
) (
    input  wire logic        clk_sys,              // Core clock, 50 MHz
    input  wire logic        rst_b,                // Synchronous reset, active low
    input  wire logic        soft_reset,           // Soft reset pulse from control logic
    input  wire logic        manual_clock,         // Control register clock bit
    input  wire logic        manual_select,        // Control register select bit
    input  wire logic        manual_write_data,    // Control register write-data bit
    output var  logic        manual_read_data,     // Control register read-data bit
    output var  logic        eeprom_serial_clock,  // Serial clock pin
    output var  logic        eeprom_select_o,      // Chip-select pin drive
    output var  logic        eeprom_select_oe,     // Chip-select pin enable, high drives
    input  wire logic        eeprom_select_i,      // Chip-select pin level
    output var  logic        eeprom_write_data,    // Serial write-data pin
    input  wire logic        eeprom_read_data,     // Serial read-data pin
    input  wire logic        infrared_strap,       // Infrared strap pin
    input  wire logic        half_duplex_strap_n,  // Half-duplex strap pin
    input  wire logic        sw_ir_write,          // Modem control bit 6 write strobe
    input  wire logic [1:0]  sw_ir_value,          // Bit 6 value per channel
    input  wire logic        sw_hd_write,          // Feature control bit 5 write strobe
    input  wire logic [1:0]  sw_hd_value,          // Bit 5 value per channel
    output var  logic [1:0]  infrared_mode,        // Modem control bit 6 per channel
    output var  logic [1:0]  half_duplex_mode,     // Feature control bit 5 per channel
    output var  logic [15:0] vendor_id,            // Vendor identification
    output var  logic [15:0] device_id,            // Device identification
    output var  logic [15:0] sub_vendor_id,        // Subsystem vendor identification
    output var  logic [15:0] sub_system_id,        // Subsystem identification
    output var  logic        eeprom_present,       // Memory sensed at start-up
    output var  logic        id_valid              // Identification loaded; fields final one cycle later
);
    typedef enum logic [1:0] {ST_SENSE, ST_START, ST_WAIT, ST_DONE} eldr_state_t;

    // Pin synchronisers
    logic [1:0] sel_sync_q, rd_sync_q, ir_sync_q, hd_sync_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sel_sync_q <= 2'h0;
            rd_sync_q  <= 2'h0;
            ir_sync_q  <= 2'h0;
            hd_sync_q  <= 2'h0;
        end else begin
            sel_sync_q <= {sel_sync_q[0], eeprom_select_i};
            rd_sync_q  <= {rd_sync_q[0], eeprom_read_data};
            ir_sync_q  <= {ir_sync_q[0], infrared_strap};
            hd_sync_q  <= {hd_sync_q[0], half_duplex_strap_n};
        end
    end

    eldr_state_t      state_q, state_d;
    logic [2:0]       sense_q, sense_d;
    logic [1:0]       widx_q,  widx_d;
    logic [3:0][15:0] words_q, words_d;
    logic             present_q, present_d;
    logic             valid_q, valid_d;
    logic [1:0]       ir_q, ir_d;
    logic [1:0]       hd_q, hd_d;
    logic             rd_start;
    logic             rd_busy;
    logic             rd_done;
    logic [15:0]      rd_word;
    logic             rd_sclk;
    logic             rd_sel;
    logic             rd_wdata;
    logic             strap_load;

    eldr_word_reader u_reader (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .start     (rd_start),
        .word_addr (6'(ID_BASE_ADDR + {4'h0, widx_q})),
        .read_bit  (rd_sync_q[1]),
        .busy      (rd_busy),
        .done      (rd_done),
        .word      (rd_word),
        .sclk      (rd_sclk),
        .sel       (rd_sel),
        .wdata     (rd_wdata)
    );

    assign rd_start   = (state_q == ST_START) && !rd_busy;
    assign strap_load = ((state_q == ST_SENSE) && (sense_q == eldr_pkg::SENSE_LAST)) ||
                        soft_reset; // R11

    always_comb begin
        state_d   = state_q;
        sense_d   = sense_q;
        widx_d    = widx_q;
        words_d   = words_q;
        present_d = present_q;
        valid_d   = valid_q;
        unique case (state_q)
            ST_SENSE: begin
                sense_d = sense_q + 3'h1;
                if (sense_q == eldr_pkg::SENSE_LAST) begin
                    present_d = sel_sync_q[1]; // R4
                    if (sel_sync_q[1]) begin
                        state_d = ST_START; // R20
                    end else begin
                        state_d = ST_DONE; // R9
                        valid_d = 1'b1;
                    end
                end
            end
            ST_START: begin
                if (rd_start) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rd_done) begin
                    words_d[widx_q] = rd_word; // R8
                    if (widx_q == eldr_pkg::ID_LAST_WORD) begin
                        state_d = ST_DONE;
                        valid_d = 1'b1; // R22
                    end else begin
                        widx_d  = widx_q + 2'h1;
                        state_d = ST_START;
                    end
                end
            end
            ST_DONE: begin
                state_d = ST_DONE;
            end
        endcase
    end

    // Strap loads beat same-cycle software writes
    always_comb begin
        ir_d = ir_q;
        hd_d = hd_q;
        if (strap_load) begin
            ir_d = {2{ir_sync_q[1]}}; // R12 R13
            hd_d = {2{hd_sync_q[1]}}; // R14 R15
        end else begin
            if (sw_ir_write) begin
                ir_d = sw_ir_value; // R12
            end
            if (sw_hd_write) begin
                hd_d = sw_hd_value; // R16
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q   <= ST_SENSE;
            sense_q   <= 3'h0;
            widx_q    <= 2'h0;
            words_q   <= '0;
            present_q <= 1'b0;
            valid_q   <= 1'b0;
            ir_q      <= 2'h0;
            hd_q      <= 2'h0;
        end else begin
            state_q   <= state_d;
            sense_q   <= sense_d;
            widx_q    <= widx_d;
            words_q   <= words_d;
            present_q <= present_d;
            valid_q   <= valid_d;
            ir_q      <= ir_d;
            hd_q      <= hd_d;
        end
    end

    // Registered outputs
    logic        ck_q, ck_d, cs_q, cs_d, cs_oe_q, cs_oe_d, di_q, di_d, mrd_q;
    logic [15:0] vid_q, vid_d, did_q, did_d, svid_q, svid_d, sid_q, sid_d;

    always_comb begin
        ck_d    = 1'b0;
        cs_d    = 1'b0;
        cs_oe_d = 1'b0;
        di_d    = 1'b0;
        if (state_q == ST_DONE) begin
            ck_d    = manual_clock; // R2 R10
            cs_d    = manual_select; // R3
            cs_oe_d = 1'b1;
            di_d    = manual_write_data; // R5
        end else if (state_q != ST_SENSE) begin
            ck_d    = rd_sclk; // R1 R7
            cs_d    = rd_sel; // R21
            cs_oe_d = 1'b1;
            di_d    = rd_wdata;
        end
        vid_d  = DEFAULT_VENDOR_ID; // R18
        did_d  = DEFAULT_DEVICE_ID;
        svid_d = eldr_pkg::ID_SUB_DEFAULT; // R19
        sid_d  = eldr_pkg::ID_SUB_DEFAULT;
        if (present_q && valid_q) begin
            vid_d  = words_q[eldr_pkg::ID_VENDOR]; // R18
            did_d  = words_q[eldr_pkg::ID_DEVICE];
            svid_d = words_q[eldr_pkg::ID_SUB_VENDOR]; // R19
            sid_d  = words_q[eldr_pkg::ID_SUB_SYSTEM];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ck_q    <= 1'b0;
            cs_q    <= 1'b0;
            cs_oe_q <= 1'b0;
            di_q    <= 1'b0;
            mrd_q   <= 1'b0;
            vid_q   <= 16'h0000;
            did_q   <= 16'h0000;
            svid_q  <= 16'h0000;
            sid_q   <= 16'h0000;
        end else begin
            ck_q    <= ck_d;
            cs_q    <= cs_d;
            cs_oe_q <= cs_oe_d;
            di_q    <= di_d;
            mrd_q   <= rd_sync_q[1]; // R6
            vid_q   <= vid_d;
            did_q   <= did_d;
            svid_q  <= svid_d;
            sid_q   <= sid_d;
        end
    end

    assign manual_read_data    = mrd_q;
    assign eeprom_serial_clock = ck_q;
    assign eeprom_select_o     = cs_q;
    assign eeprom_select_oe    = cs_oe_q;
    assign eeprom_write_data   = di_q;
    assign infrared_mode       = ir_q;
    assign half_duplex_mode    = hd_q;
    assign vendor_id           = vid_q;
    assign device_id           = did_q;
    assign sub_vendor_id       = svid_q;
    assign sub_system_id       = sid_q;
    assign eeprom_present      = present_q;
    assign id_valid            = valid_q;
endmodule : eldr_loader // eldr_loader
`default_nettype wire

// ### tb/eldr_loader_assertions.sv
// Port checks for the loader
`timescale 1ns/10ps
`default_nettype none
module eldr_loader_assertions #(
    parameter logic [15:0] DEFAULT_VENDOR_ID = 16'h1234, // Arbitrary value
    parameter logic [15:0] DEFAULT_DEVICE_ID = 16'h5678  // Arbitrary value
) (
    input wire logic        clk_sys,             // Clock
    input wire logic        rst_b,               // Reset
    input wire logic        soft_reset,          // Soft reset
    input wire logic        manual_clock,        // Manual clock
    input wire logic        manual_select,       // Manual select
    input wire logic        manual_write_data,   // Manual data
    input wire logic        manual_read_data,    // Read bit
    input wire logic        eeprom_serial_clock, // Clock pin
    input wire logic        eeprom_select_o,     // Select drive
    input wire logic        eeprom_select_oe,    // Select enable
    input wire logic        eeprom_write_data,   // Data pin
    input wire logic        eeprom_read_data,    // Read pin
    input wire logic        infrared_strap,      // Strap
    input wire logic        half_duplex_strap_n, // Strap
    input wire logic        sw_ir_write,         // Strobe
    input wire logic [1:0]  sw_ir_value,         // Value
    input wire logic        sw_hd_write,         // Strobe
    input wire logic [1:0]  sw_hd_value,         // Value
    input wire logic [1:0]  infrared_mode,       // Mode
    input wire logic [1:0]  half_duplex_mode,    // Mode
    input wire logic [15:0] vendor_id,           // Id
    input wire logic [15:0] device_id,           // Id
    input wire logic [15:0] sub_vendor_id,       // Id
    input wire logic [15:0] sub_system_id,       // Id
    input wire logic        eeprom_present,      // Sensed
    input wire logic        id_valid             // Done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [7:0] run_q, run_d;
    logic       clk_q, sel_q;
    // Cycles since clock change or select rise
    always_comb begin
        run_d = run_q + 8'h01;
        if (!rst_b || eeprom_serial_clock != clk_q || (eeprom_select_o && !sel_q)) begin
            run_d = 8'h00;
        end
    end
    always_ff @(posedge clk_sys) begin
        run_q <= run_d;
        clk_q <= eeprom_serial_clock;
        sel_q <= eeprom_select_o;
    end
    AST_SCLK_HALF: assert property (!id_valid && eeprom_select_o && $past(eeprom_select_o)
        && $changed(eeprom_serial_clock) |-> run_q == 8'h7f) else $error("Bad half period");
    AST_SW_IR: assert property (id_valid && sw_ir_write && !soft_reset
        |=> infrared_mode == $past(sw_ir_value)) else $error("IR write lost");
    AST_SW_HD: assert property (id_valid && sw_hd_write && !soft_reset
        |=> half_duplex_mode == $past(sw_hd_value)) else $error("HD write lost");
    AST_SOFT_IR: assert property (id_valid && soft_reset
        |=> infrared_mode == {2{$past(infrared_strap, 3)}}) else $error("Strap lost");
    AST_SOFT_HD: assert property (id_valid && soft_reset
        |=> half_duplex_mode == {2{$past(half_duplex_strap_n, 3)}}) else $error("Strap missed");
    AST_OE_ON: assert property (id_valid && $past(id_valid) |-> eeprom_select_oe)
        else $error("Select undriven");
    AST_NOMEM_IDS: assert property ($rose(id_valid) && !eeprom_present |-> ##[0:2]
        {vendor_id, device_id, sub_vendor_id, sub_system_id}
        == {DEFAULT_VENDOR_ID, DEFAULT_DEVICE_ID, 32'h0}) else $error("Bad defaults");
    AST_ID_HOLD: assert property (id_valid && $past(id_valid, 3) |->
        $stable({vendor_id, device_id, sub_vendor_id, sub_system_id})) else $error("Ids moved");
    AST_MANUAL: assert property (id_valid && $past(id_valid, 3)
        |-> {eeprom_serial_clock, eeprom_select_o, eeprom_write_data}
        == $past({manual_clock, manual_select, manual_write_data})) else $error("Pins not manual");
    AST_READ_LAG: assert property (id_valid && $past(id_valid, 4)
        |-> manual_read_data == $past(eeprom_read_data, 3)) else $error("Read bit wrong");
    cover property ($rose(id_valid) && eeprom_present);
    cover property (id_valid && soft_reset);
    cover property (id_valid && sw_hd_write);
endmodule // eldr_loader_assertions
bind eldr_loader eldr_loader_assertions #(
    .DEFAULT_VENDOR_ID(DEFAULT_VENDOR_ID), .DEFAULT_DEVICE_ID(DEFAULT_DEVICE_ID)
) u_eldr_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .soft_reset(soft_reset), .manual_clock(manual_clock),
    .manual_select(manual_select), .manual_write_data(manual_write_data),
    .manual_read_data(manual_read_data), .eeprom_serial_clock(eeprom_serial_clock),
    .eeprom_select_o(eeprom_select_o), .eeprom_select_oe(eeprom_select_oe),
    .eeprom_write_data(eeprom_write_data), .eeprom_read_data(eeprom_read_data),
    .infrared_strap(infrared_strap), .half_duplex_strap_n(half_duplex_strap_n),
    .sw_ir_write(sw_ir_write), .sw_ir_value(sw_ir_value), .sw_hd_write(sw_hd_write),
    .sw_hd_value(sw_hd_value), .infrared_mode(infrared_mode),
    .half_duplex_mode(half_duplex_mode), .vendor_id(vendor_id), .device_id(device_id),
    .sub_vendor_id(sub_vendor_id), .sub_system_id(sub_system_id),
    .eeprom_present(eeprom_present), .id_valid(id_valid)
);
`default_nettype wire

// ### tb/eldr_eeprom_model.sv
// Behavioural serial memory with four identification words
`timescale 1ns/10ps
`default_nettype none
module eldr_eeprom_model #(
    parameter logic [15:0] W0 = 16'h0000, // Word 0
    parameter logic [15:0] W1 = 16'h0000, // Word 1
    parameter logic [15:0] W2 = 16'h0000, // Word 2
    parameter logic [15:0] W3 = 16'h0000  // Word 3
) (
    input  wire logic sclk,    // Serial clock
    input  wire logic sel,     // Chip select
    input  wire logic din,     // Command bits in
    output var  logic dout,    // Data bits out
    output var  int   served,  // Read commands taken
    output var  int   bad_cmd  // Malformed or misordered commands
);
    localparam logic [15:0] WORDS [4] = '{W0, W1, W2, W3};
    logic [8:0]  cmd = 9'h000;
    logic [15:0] data = 16'h0000;
    int          n = 0;
    initial begin
        dout = 1'b0;
        served = 0;
        bad_cmd = 0;
    end
    // Released output flips on deselect
    always @(negedge sel) begin
        n = 0;
        dout = ~dout;
    end
    always @(posedge sclk) begin
        if (sel) begin
            if (n < 9) cmd = {cmd[7:0], din};
            if (n == 8) begin
                if (cmd[8:6] !== 3'h6 || cmd[5:0] !== 6'(served)) bad_cmd++;
                data = WORDS[cmd[1:0]];
                served++;
            end
            if (n >= 9 && n <= 24) dout = data[24 - n];
            n++;
        end
    end
endmodule // eldr_eeprom_model
`default_nettype wire

// ### tb/eldr_loader_tb.sv
// Self-checking bench for the identification loader
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module eldr_loader_tb;
    localparam logic [15:0] VID = 16'h2bd1; // Arbitrary value
    localparam logic [15:0] DID = 16'h7e40; // Arbitrary value
    localparam logic [15:0] W0 = 16'hc3a5, W1 = 16'h5a0f, W2 = 16'h9e61, W3 = 16'h0ff1;
    logic clk_sys = 1'b0, rst_b = 1'b0, soft_reset = 1'b0, fitted = 1'b0;
    logic manual_clock = 1'b0, manual_select = 1'b0, manual_write_data = 1'b0;
    logic infrared_strap = 1'b1, half_duplex_strap_n = 1'b0, sw_ir_write = 1'b0;
    logic sw_hd_write = 1'b0;
    logic [1:0] sw_ir_value = 2'h0, sw_hd_value = 2'h0, infrared_mode, half_duplex_mode;
    logic manual_read_data, eeprom_serial_clock, eeprom_select_o, eeprom_select_oe;
    logic eeprom_write_data, eeprom_read_data, eeprom_present, id_valid;
    logic [15:0] vendor_id, device_id, sub_vendor_id, sub_system_id;
    wire logic eeprom_select_i;
    int bad_count = 0, compares = 0, cycles = 0, served, bad_cmd;
    // Select pull-up exists only with a memory fitted
    assign eeprom_select_i = eeprom_select_oe ? eeprom_select_o : fitted;
    eldr_loader #(.DEFAULT_VENDOR_ID(VID), .DEFAULT_DEVICE_ID(DID)) DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .soft_reset(soft_reset), .manual_clock(manual_clock),
        .manual_select(manual_select), .manual_write_data(manual_write_data),
        .manual_read_data(manual_read_data), .eeprom_serial_clock(eeprom_serial_clock),
        .eeprom_select_o(eeprom_select_o), .eeprom_select_oe(eeprom_select_oe),
        .eeprom_select_i(eeprom_select_i), .eeprom_write_data(eeprom_write_data),
        .eeprom_read_data(eeprom_read_data), .infrared_strap(infrared_strap),
        .half_duplex_strap_n(half_duplex_strap_n), .sw_ir_write(sw_ir_write),
        .sw_ir_value(sw_ir_value), .sw_hd_write(sw_hd_write), .sw_hd_value(sw_hd_value),
        .infrared_mode(infrared_mode), .half_duplex_mode(half_duplex_mode),
        .vendor_id(vendor_id), .device_id(device_id), .sub_vendor_id(sub_vendor_id),
        .sub_system_id(sub_system_id), .eeprom_present(eeprom_present), .id_valid(id_valid)
    );
    eldr_eeprom_model #(.W0(W0), .W1(W1), .W2(W2), .W3(W3)) MEM (
        .sclk(eeprom_serial_clock), .sel(eeprom_select_i & fitted), .din(eeprom_write_data),
        .dout(eeprom_read_data), .served(served), .bad_cmd(bad_cmd)
    );
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("Compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        tick(8);
        rst_b <= 1'b1;
    endtask
    task automatic wait_valid();
        for (int i = 0; i < 30000 && id_valid !== 1'b1; i++) @(posedge clk_sys);
        tick(2);
        #1;
    endtask
    task automatic t_no_memory();
        wait_valid();
        `CHK(eeprom_present, 1'b0)
        `CHK({vendor_id, device_id}, {VID, DID})
        `CHK({sub_vendor_id, sub_system_id}, 32'h0)
        `CHK(served, 0)
        `CHK(infrared_mode, 2'h3)
        `CHK(half_duplex_mode, 2'h0)
    endtask
    task automatic t_manual();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            {manual_clock, manual_select, manual_write_data} <= 3'(i);
            tick(6);
            #1;
            `CHK({eeprom_serial_clock, eeprom_select_o, eeprom_write_data}, 3'(i))
            `CHK(manual_read_data, eeprom_read_data)
        end
    endtask
    task automatic t_soft();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            {half_duplex_strap_n, infrared_strap} <= k[1:0];
            tick(4);
            soft_reset <= 1'b1;
            @(posedge clk_sys);
            soft_reset <= 1'b0;
            tick(1);
            #1;
            `CHK(infrared_mode, {2{k[0]}})
            `CHK(half_duplex_mode, {2{k[1]}})
        end
    endtask
    task automatic t_sw();
        @(posedge clk_sys);
        {sw_ir_write, sw_ir_value, sw_hd_write, sw_hd_value} <= 6'h35;
        @(posedge clk_sys);
        {sw_ir_value, sw_hd_value} <= 4'h6;
        #1;
        `CHK({infrared_mode, half_duplex_mode}, 4'h9)
        @(posedge clk_sys);
        {sw_ir_write, sw_hd_write} <= 2'h0;
        #1;
        `CHK({infrared_mode, half_duplex_mode}, 4'h6)
    endtask
    task automatic t_strap_wins();
        @(posedge clk_sys);
        {soft_reset, sw_ir_write, sw_ir_value, sw_hd_write, sw_hd_value} <= 7'h64;
        @(posedge clk_sys);
        {soft_reset, sw_ir_write, sw_hd_write} <= 3'h0;
        tick(1);
        #1;
        `CHK({infrared_mode, half_duplex_mode}, 4'hf)
    endtask
    task automatic t_memory();
        tick(20);
        #1;
        `CHK({id_valid, eeprom_select_oe}, 2'h1)
        wait_valid();
        `CHK(eeprom_present, 1'b1)
        `CHK({vendor_id, device_id}, {W0, W1})
        `CHK({sub_vendor_id, sub_system_id}, {W2, W3})
        `CHK(served, 4)
        `CHK(bad_cmd, 0)
        `CHK({infrared_mode, half_duplex_mode}, 4'h3)
    endtask
    initial begin
        do_reset();
        t_no_memory();
        t_manual();
        t_soft();
        t_sw();
        t_strap_wins();
        @(posedge clk_sys);
        {fitted, infrared_strap, half_duplex_strap_n} <= 3'h5;
        {manual_clock, manual_select, manual_write_data} <= 3'h0;
        do_reset();
        t_memory();
        t_manual();
        end_sim();
    end
endmodule // eldr_loader_tb
`default_nettype wire
